// ---- hmpc_pkg.sv ----
// package: constants and types for the halt mode power control block
package hmpc_pkg;
    localparam int NUM_PERIPH = 8;
    localparam logic [NUM_PERIPH-1:0] PERIPH_EN_RESET = 8'hFF;
    localparam logic [1:0] WAKE_NONE = 2'h0;
    localparam logic [1:0] WAKE_IRQ  = 2'h1;
    localparam logic [1:0] WAKE_WDT  = 2'h2;
    localparam logic [1:0] WAKE_RST  = 2'h3;
    typedef enum logic [1:0] {
        HMPC_RUN,
        HMPC_HALT,
        HMPC_WAKE
    } hmpc_state_t;
endpackage

// ---- hmpc_ctrl.sv ----
// halt mode power control: core stop, clock/peripheral gating, wake-up
`timescale 1ns/1ps

// Functional notes
// - halt instruction stops core, enabled peripherals stay active
// - primary oscillator stays enabled during halt
// - system clock keeps toggling for peripherals
// - core stopped, program counter holds
// - watchdog oscillator keeps running during halt
// - watchdog counts in halt if enabled before
// - enabled peripherals run, disabled ones stay off
// - interrupt, watchdog, resets end halt
// - each peripheral may be disabled individually
// - one control bit gates each peripheral clock
module hmpc_ctrl #(
    parameter int NUM_PERIPH = hmpc_pkg::NUM_PERIPH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  halt_exec,
    input  wire logic                  irq_pending,
    input  wire logic                  wdt_enable,
    input  wire logic                  wdt_timeout,
    input  wire logic                  por_event,
    input  wire logic                  brownout_event,
    input  wire logic                  ext_reset_pin,
    input  wire logic [NUM_PERIPH-1:0] periph_disable,
    output logic                       core_clk_en,
    output logic                       program_counter_hold,
    output logic                       halted,
    output logic                       fetch_resume,
    output logic                       prim_osc_en,
    output logic                       sys_clk_en,
    output logic                       wdt_osc_en,
    output logic                       wdt_count_en,
    output logic [NUM_PERIPH-1:0]      periph_clk_en,
    output logic [1:0]                 wake_cause
);
    // the reset vector bounds how many gates this block can serve
    if (NUM_PERIPH < 1 || NUM_PERIPH > $bits(hmpc_pkg::PERIPH_EN_RESET)) begin : g_bad_width
        $error("NUM_PERIPH out of range");
    end

    // =====================================================================
    // external reset pin synchroniser
    logic [1:0] rst_pin_sync;
    logic       ext_rst;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_pin_sync <= 2'h0;
        end else begin
            rst_pin_sync <= {rst_pin_sync[0], ext_reset_pin};
        end
    end
    assign ext_rst = rst_pin_sync[1];

    logic any_reset;
    logic wake_req;
    assign any_reset = por_event | brownout_event | ext_rst;
    assign wake_req  = irq_pending | wdt_timeout | any_reset;

    // =====================================================================
    // halt state machine
    hmpc_pkg::hmpc_state_t state;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= hmpc_pkg::HMPC_RUN;
        end else begin
            case (state)
                hmpc_pkg::HMPC_RUN: begin
                    if (halt_exec && !wake_req) begin
                        state <= hmpc_pkg::HMPC_HALT;
                    end
                end
                hmpc_pkg::HMPC_HALT: begin
                    if (wake_req) begin
                        state <= hmpc_pkg::HMPC_WAKE;
                    end
                end
                hmpc_pkg::HMPC_WAKE: state <= hmpc_pkg::HMPC_RUN;
                default:             state <= hmpc_pkg::HMPC_RUN;
            endcase
        end
    end

    // =====================================================================
    // core controls: stopped only while halted
    // a wake source seen this cycle releases the core at once
    function automatic logic stays_halted(input hmpc_pkg::hmpc_state_t s, input logic wake);
        return (s == hmpc_pkg::HMPC_HALT) && !wake;
    endfunction

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            core_clk_en          <= 1'b1;
            program_counter_hold <= 1'b0;
            halted               <= 1'b0;
        end else begin
            core_clk_en          <= !stays_halted(state, wake_req);
            program_counter_hold <=  stays_halted(state, wake_req);
            halted               <=  stays_halted(state, wake_req);
        end
    end

    // one-cycle pulse on the cycle the core restarts after interrupt wake
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            fetch_resume <= 1'b0;
            wake_cause   <= hmpc_pkg::WAKE_NONE;
        end else begin
            fetch_resume <= (state == hmpc_pkg::HMPC_HALT)
                            && irq_pending && !any_reset;
            if (state == hmpc_pkg::HMPC_HALT && wake_req) begin
                // resets outrank watchdog, watchdog outranks interrupts
                if (any_reset) begin
                    wake_cause <= hmpc_pkg::WAKE_RST;
                end else if (wdt_timeout) begin
                    wake_cause <= hmpc_pkg::WAKE_WDT;
                end else begin
                    wake_cause <= hmpc_pkg::WAKE_IRQ;
                end
            end
        end
    end

    // =====================================================================
    // system clock and oscillators never drop in halt; stop mode is elsewhere
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prim_osc_en  <= 1'b1;
            sys_clk_en   <= 1'b1;
            wdt_osc_en   <= 1'b1;
            wdt_count_en <= 1'b0;
        end else begin
            prim_osc_en  <= 1'b1;
            sys_clk_en   <= 1'b1;
            wdt_osc_en   <= 1'b1;
            wdt_count_en <= wdt_enable;
        end
    end

    // per-peripheral gating, independent of halt state
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    periph_clk_en[gi] <= hmpc_pkg::PERIPH_EN_RESET[gi];
                end else begin
                    periph_clk_en[gi] <= !periph_disable[gi];
                end
            end
        end
    endgenerate

    // =====================================================================
    // assertions
    // a wake source in the first halted cycle cancels the stop
    a_halt_entry_stops: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_RUN && halt_exec && !wake_req
        |=> (state == hmpc_pkg::HMPC_HALT)
            and (!wake_req |=> (program_counter_hold && !core_clk_en)))
        else $error("halt entry did not stop core");

    a_core_runs_free: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state != hmpc_pkg::HMPC_HALT |=> core_clk_en && !program_counter_hold)
        else $error("core stopped outside halt");

    a_osc_stays_on: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        halted |-> prim_osc_en)
        else $error("primary oscillator off in halt");

    a_sysclk_stays_on: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        halted |-> sys_clk_en)
        else $error("system clock off in halt");

    a_counter_held: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_HALT && !wake_req
        |=> program_counter_hold && halted && !core_clk_en)
        else $error("program counter not held in halt");

    a_wdt_osc_runs: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        halted |-> wdt_osc_en)
        else $error("watchdog oscillator off in halt");

    a_wdt_count_follows: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        halted && $past(wdt_enable) |-> wdt_count_en)
        else $error("watchdog not counting in halt");

    a_periph_gate_bit: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        ##1 periph_clk_en == ~$past(periph_disable))
        else $error("peripheral gate mismatch");

    a_wake_exits_halt: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_HALT && wake_req
        |=> !program_counter_hold && !halted && core_clk_en)
        else $error("wake event did not end halt");

    a_reset_cause_wins: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_HALT && any_reset |=> wake_cause == hmpc_pkg::WAKE_RST)
        else $error("reset wake not reported as reset");

    a_wdt_cause_next: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_HALT && wdt_timeout && !any_reset
        |=> wake_cause == hmpc_pkg::WAKE_WDT)
        else $error("watchdog wake not reported as watchdog");

    a_halt_refused: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_RUN && wake_req |=> state != hmpc_pkg::HMPC_HALT)
        else $error("halt taken while a wake source was active");

    a_irq_resumes: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_HALT && irq_pending && !any_reset
        |=> fetch_resume && core_clk_en)
        else $error("interrupt wake did not resume fetch");

    c_halt_entered: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(halted));
    c_irq_wake: cover property (@(posedge sys_clk) disable iff (!nrst)
        halted ##1 fetch_resume);
    c_wdt_wake: cover property (@(posedge sys_clk) disable iff (!nrst)
        halted && wdt_timeout && !irq_pending && !any_reset);
    c_reset_wake: cover property (@(posedge sys_clk) disable iff (!nrst)
        halted && ext_rst);
    c_halt_refused: cover property (@(posedge sys_clk) disable iff (!nrst)
        state == hmpc_pkg::HMPC_RUN && halt_exec && wake_req);
endmodule

// ---- hmpc_core_model.sv ----
// core model: program counter that advances only while the core clock runs
`timescale 1ns/1ps
module hmpc_core_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       core_clk_en,
    input  wire logic       program_counter_hold,
    output logic      [7:0] program_counter
);
    // a stalled core must show a frozen count, so no free-running fetch here
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            program_counter <= 8'h00;
        end else if (core_clk_en && !program_counter_hold) begin
            program_counter <= program_counter + 8'h01;
        end
    end
endmodule

// ---- tb_halt_mode_power_control.sv ----
// testbench for the halt mode power control block
`timescale 1ns/1ps
module tb_halt_mode_power_control;
    logic       sys_clk, nrst, halt_exec, irq_pending, wdt_enable, wdt_timeout;
    logic       por_event, brownout_event, ext_reset_pin, core_clk_en, program_counter_hold;
    logic       halted, fetch_resume, prim_osc_en, sys_clk_en, wdt_osc_en, wdt_count_en;
    logic [7:0] periph_disable, periph_clk_en, program_counter, count_seen;
    logic [1:0] wake_cause;
    int         num_errors = 0;
    int         n_checks = 0;
    hmpc_ctrl DUT (.sys_clk, .nrst, .halt_exec, .irq_pending, .wdt_enable, .wdt_timeout,
        .por_event, .brownout_event, .ext_reset_pin, .periph_disable, .core_clk_en,
        .program_counter_hold, .halted, .fetch_resume, .prim_osc_en, .sys_clk_en,
        .wdt_osc_en, .wdt_count_en, .periph_clk_en, .wake_cause);
    hmpc_core_model core (.sys_clk, .nrst, .core_clk_en, .program_counter_hold,
        .program_counter);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ==========================================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic set_src(input int s, input logic v);
        case (s)
            0: irq_pending = v;
            1: wdt_timeout = v;
            2: por_event = v;
            3: brownout_event = v;
            default: ext_reset_pin = v;
        endcase
    endtask
    // bounded wait: ext pin wake carries extra sync latency
    task automatic wait_halted(input logic want);
        for (int i = 0; i < 8 && halted !== want; i++) tick(1);
    endtask
    function automatic logic [1:0] exp_cause(input int s);
        return (s == 0) ? hmpc_pkg::WAKE_IRQ : (s == 1) ? hmpc_pkg::WAKE_WDT : hmpc_pkg::WAKE_RST;
    endfunction
    task automatic run_halt(input int s);
        periph_disable = 8'($urandom);
        wdt_enable = 1'($urandom_range(0, 1));
        halt_exec = 1'b1;
        tick(1);
        halt_exec = 1'b0;
        wait_halted(1'b1);
        check(halted, 8'h01);
        check(core_clk_en, 8'h00);
        check(program_counter_hold, 8'h01);
        check({prim_osc_en, sys_clk_en, wdt_osc_en}, 8'h07);
        check(wdt_count_en, wdt_enable);
        check(periph_clk_en, ~periph_disable);
        count_seen = program_counter;
        tick($urandom_range(1, 5));
        check(program_counter, count_seen);
        set_src(s, 1'b1);
        wait_halted(1'b0);
        check(wake_cause, exp_cause(s));
        check(fetch_resume, (s == 0) ? 8'h01 : 8'h00);
        check(core_clk_en, 8'h01);
        set_src(s, 1'b0);
        tick(4);
        check(program_counter != count_seen, 8'h01);
        check(periph_clk_en, ~periph_disable);
        $display("test source %0d done", s);
    endtask
    // ==========================================
    // main sequence
    initial begin
        {nrst, halt_exec, irq_pending, wdt_enable, wdt_timeout} = 5'h00;
        {por_event, brownout_event, ext_reset_pin} = 3'h0;
        periph_disable = 8'h00;
        void'($urandom(32'h72D8));
        tick(6);
        nrst = 1'b1;
        check({halted, program_counter_hold, wake_cause}, 8'h00);
        // halt request while an interrupt waits must be refused
        irq_pending = 1'b1;
        halt_exec = 1'b1;
        tick(4);
        check(halted, 8'h00);
        {irq_pending, halt_exec} = 2'h0;
        tick(4);
        $display("test refusal done");
        for (int r = 0; r < 4; r++) begin
            for (int s = 0; s < 5; s++) run_halt(s);
        end
        stop_test();
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        stop_test();
    end
endmodule
